// ==== fmc_core.sv ====
// Four-bit microcomputer core with program store, data memory, adder,
// status logic, strobe latches, output latch and decode array.
// Assumes keys are synchronous to ref_clk; program loaded over AXI4-Lite.
//
// Summary of operation
// (RULE1) Eight-bit opcodes, up to 256 operations
// (RULE2) Sixteen pages of 64 words, page register
// (RULE3) Fixed start address, shift-register counter steps
// (RULE4) Taken branch or call loads six-bit target
// (RULE5) One return register restored by return
// (RULE6) Page buffer loaded by constant, copied on branch
// (RULE7) Page buffer keeps return page during call
// (RULE8) Four files of sixteen four-bit words
// (RULE9) File selector only loaded or complemented
// (RULE10) Word selector compare, load, step, transfer
// (RULE11) Memory written from accumulator or constant
// (RULE12) Memory bits set, cleared, tested to status
// (RULE13) N operand: inverted or true accumulator, others
// (RULE14) P operand: word selector, memory, constant, keys
// (RULE15) Results to word selector or accumulator only
// (RULE16) Branches and calls only when status one
// (RULE17) No carry clears status one cycle
// (RULE18) Equal compare clears status one cycle
// (RULE19) Keys routed to adder, tested or loaded
// (RULE20) Strobe starts peripheral, keys sampled in step
// (RULE21) Thirteen strobe latches addressed by word selector
// (RULE22) Output latch takes accumulator and status latch
// (RULE23) Twenty-term decode array drives eight outputs
// (RULE24) Every instruction takes six clock pulses
// (RULE25) Status returns to one after one cycle
// (RULE26) Inequality compare also loads status latch
// (RULE27) Entry address and counter feedback are parameters
// (RULE28) Decode array masks are parameters
`timescale 1ns/10ps
module fmc_core
#(
    parameter logic [3:0] ENTRY_PAGE = 4'hF,
    parameter logic [5:0] ENTRY_PC = 6'h00,
    parameter logic [5:0] PC_TAPS = 6'h30,
    parameter logic [fmc_pkg::PLA_TERMS*10-1:0] PLA_IN_MASK = '0,
    parameter logic [fmc_pkg::PLA_TERMS*8-1:0] PLA_OUT_MASK = '0
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Key inputs
    input wire logic key_in_bit0,
    input wire logic key_in_bit1,
    input wire logic key_in_bit2,
    input wire logic key_in_bit3,
    // Strobe, decoded and status latch outputs
    output logic [fmc_pkg::R_LINES-1:0] r_out,
    output logic [fmc_pkg::O_LINES-1:0] decoded_out,
    output logic status_latch_bit,
    // AXI4-Lite write channels
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import fmc_pkg::*;

    logic [7:0] rom [ROM_WORDS];      // Program store
    logic [3:0] ram [RAM_WORDS];      // Data memory
    logic [2:0] phase;                // Pulse within instruction cycle
    logic step;                       // Execute pulse
    logic [3:0] page;                 // Page address register
    logic [3:0] pbuf;                 // Page buffer
    logic [5:0] pc;                   // In-page counter
    logic [5:0] ret_pc;               // Return register
    logic in_call;                    // Return pending
    logic [3:0] acc;                  // Accumulator
    logic [3:0] y;                    // Word selector
    logic [1:0] x;                    // File selector
    logic status;                     // Branch condition
    logic [4:0] o_latch;              // Output latch
    logic [3:0] keys;                 // Key word
    logic [3:0] mem;                  // Addressed memory word
    logic [7:0] opc;                  // Current opcode
    logic [5:0] next_pc;              // Sequential successor
    logic [4:0] sum;                  // Adder output with carry
    logic next_status;                // Status for next cycle
    logic cond_ok;                    // Branch or call taken
    fmc_alu_s alu;                    // Operand selection
    fmc_op_e op;                      // Short operation
    fmc_ctrl_s ctrl;                  // Software control
    logic [9:0] paddr;                // Program load address
    logic [3:0] bmask;                // Selected memory bit
    logic [O_LINES-1:0] pla_or;       // Decode array result
    logic [PLA_TERMS-1:0] term_hit;   // Active product terms
    logic [4:0] aw_addr;              // Captured write address
    logic [31:0] w_data;              // Captured write data
    logic w_lane0;                    // Captured lane-0 byte strobe
    logic do_write;                   // Register write strobe

    assign keys = {key_in_bit3, key_in_bit2, key_in_bit1, key_in_bit0};
    assign opc = rom[{page, pc}]; // RULE2
    assign mem = ram[{x, y}]; // RULE8
    assign op = fmc_op_e'(opc[4:0]); // RULE1
    assign bmask = 4'h1 << opc[1:0];
    // Shift-register successor with parameter feedback
    assign next_pc = {pc[4:0], ~^(pc & PC_TAPS)}; // RULE3 RULE27
    assign cond_ok = status && opc[7]; // RULE16

    // Phase divider: one execute pulse per six clocks
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            phase <= '0;
        else if (!ctrl.run || ctrl.restart)
            phase <= '0;
        else if (phase == PHASE_LAST) // RULE24
            phase <= '0;
        else
            phase <= phase + 3'h1;
    end
    assign step = ctrl.run && (phase == PHASE_LAST);

    // Operand selectors and status source
    always_comb
    begin
        alu = '0;
        if (opc[7:5] == 3'h0)
        begin
            unique case (op)
                // Adder operations on memory, accumulator, word selector and constants
                OP_AMAAC: alu = '{mem, acc, 1'b0, 1'b1, 1'b0};
                OP_SAMAN: alu = '{mem, ~acc, 1'b1, 1'b1, 1'b0}; // RULE13
                OP_IMAC: alu = '{mem, NIB_ZERO, 1'b1, 1'b1, 1'b0};
                OP_DMAN: alu = '{mem, NIB_ONES, 1'b0, 1'b1, 1'b0};
                OP_IA: alu = '{NIB_ZERO, acc, 1'b1, 1'b0, 1'b0};
                OP_IYC: alu = '{y, NIB_ZERO, 1'b1, 1'b1, 1'b0}; // RULE14
                OP_DAN: alu = '{NIB_ONES, acc, 1'b0, 1'b1, 1'b0};
                OP_DYN: alu = '{y, NIB_ONES, 1'b0, 1'b1, 1'b0};
                OP_A6AAC: alu = '{ADD_SIX, acc, 1'b0, 1'b1, 1'b0};
                OP_A8AAC: alu = '{ADD_EIGHT, acc, 1'b0, 1'b1, 1'b0};
                OP_A10AAC: alu = '{ADD_TEN, acc, 1'b0, 1'b1, 1'b0};
                OP_CPAIZ: alu = '{NIB_ZERO, ~acc, 1'b1, 1'b1, 1'b0};
                OP_ALEM: alu = '{mem, ~acc, 1'b1, 1'b1, 1'b0};
                // Logical compares and transfers
                OP_MNEZ: alu = '{mem, NIB_ZERO, 1'b0, 1'b0, 1'b1};
                OP_YNEA: alu = '{y, acc, 1'b0, 1'b0, 1'b1};
                OP_KNEZ: alu = '{keys, NIB_ZERO, 1'b0, 1'b0, 1'b1}; // RULE19
                OP_TKA: alu = '{keys, NIB_ZERO, 1'b0, 1'b0, 1'b0};
                OP_TMY, OP_TMA: alu = '{mem, NIB_ZERO, 1'b0, 1'b0, 1'b0};
                OP_TYA: alu = '{y, NIB_ZERO, 1'b0, 1'b0, 1'b0};
                OP_TAY: alu = '{NIB_ZERO, acc, 1'b0, 1'b0, 1'b0};
                default: alu = '0;
            endcase
        end
        else if (opc[7:4] == GRP_ALEC)
            alu = '{opc[3:0], ~acc, 1'b1, 1'b1, 1'b0};
        else if (opc[7:4] == GRP_YNEC)
            alu = '{y, opc[3:0], 1'b0, 1'b0, 1'b1}; // RULE10
        else if (opc[7:4] == GRP_BITS && opc[3:2] == BITS_TEST)
            alu = '{mem & bmask, NIB_ZERO, 1'b0, 1'b0, 1'b1}; // RULE12
    end

    assign sum = {1'b0, alu.p} + {1'b0, alu.n} + {4'h0, alu.cin};
    // Default one; carry or inequality only when the op routes them
    assign next_status = alu.use_carry ? sum[4] :
        (alu.use_cmp ? (alu.p != alu.n) : 1'b1); // RULE17 RULE18 RULE25

    // Sequencer: counter, page, buffer, return register, status
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pc <= ENTRY_PC;
            page <= ENTRY_PAGE;
            pbuf <= ENTRY_PAGE;
            ret_pc <= '0;
            in_call <= 1'b0;
            status <= 1'b1;
        end
        else if (ctrl.restart)
        begin
            pc <= ENTRY_PC; // RULE3
            page <= ENTRY_PAGE;
            pbuf <= ENTRY_PAGE;
            in_call <= 1'b0;
            status <= 1'b1;
        end
        else if (step)
        begin
            status <= next_status; // RULE16
            pc <= next_pc;
            if (opc[7:6] == GRP_BRANCH && cond_ok)
            begin
                pc <= opc[5:0]; // RULE4
                page <= pbuf; // RULE6
            end
            else if (opc[7:6] == GRP_CALL && cond_ok && !in_call)
            begin
                pc <= opc[5:0]; // RULE4
                ret_pc <= next_pc; // RULE5
                page <= pbuf;
                pbuf <= page; // RULE7
                in_call <= 1'b1;
            end
            else if (opc[7:5] == 3'h0 && op == OP_RETN)
            begin
                if (in_call)
                begin
                    pc <= ret_pc; // RULE5
                    page <= pbuf; // RULE7
                end
                in_call <= 1'b0;
            end
            else if (opc[7:4] == GRP_LDP)
                pbuf <= opc[3:0]; // RULE6
        end
    end

    // Accumulator, word selector and file selector
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc <= '0;
            y <= '0;
            x <= '0;
        end
        else if (step && opc[7:5] == 3'h0)
        begin
            unique case (op)
                OP_COMX: x <= ~x; // RULE9
                OP_TAY, OP_TMY, OP_IYC, OP_DYN: y <= sum[3:0]; // RULE15
                OP_TAMIY: y <= y + 4'h1; // RULE10
                OP_TYA, OP_TMA, OP_AMAAC, OP_SAMAN, OP_IMAC, OP_DMAN,
                OP_IA, OP_DAN, OP_A6AAC, OP_A8AAC, OP_A10AAC, OP_CPAIZ,
                OP_TKA: acc <= sum[3:0]; // RULE15 RULE19
                OP_CLA, OP_TAMZA: acc <= '0;
                OP_XMA: acc <= mem;
                default: acc <= acc;
            endcase
        end
        else if (step)
        begin
            if (opc[7:4] == GRP_TCY)
                y <= opc[3:0]; // RULE10
            else if (opc[7:4] == GRP_TCMIY)
                y <= y + 4'h1;
            else if (opc[7:4] == GRP_BITS && opc[3:2] == BITS_LDX)
                x <= opc[1:0]; // RULE9
        end
    end

    // Data memory writes
    always_ff @(posedge ref_clk)
    begin
        if (step && opc[7:5] == 3'h0 &&
            (op == OP_TAM || op == OP_TAMIY || op == OP_TAMZA ||
             op == OP_XMA))
            ram[{x, y}] <= acc; // RULE11
        else if (step && opc[7:4] == GRP_TCMIY)
            ram[{x, y}] <= opc[3:0]; // RULE11
        else if (step && opc[7:4] == GRP_BITS && opc[3:2] == BITS_SET)
            ram[{x, y}] <= mem | bmask; // RULE12
        else if (step && opc[7:4] == GRP_BITS && opc[3:2] == BITS_RST)
            ram[{x, y}] <= mem & ~bmask; // RULE12
    end

    // Strobe latches, status latch and output latch
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r_out <= '0;
            status_latch_bit <= 1'b0;
            o_latch <= '0;
        end
        else if (step && opc[7:5] == 3'h0)
        begin
            if (op == OP_SETR && y < 4'(R_LINES))
                r_out[y] <= 1'b1; // RULE21 RULE20
            else if (op == OP_RSTR && y < 4'(R_LINES))
                r_out[y] <= 1'b0; // RULE21
            else if (op == OP_YNEA)
                status_latch_bit <= next_status; // RULE26
            else if (op == OP_TDO)
                o_latch <= {status_latch_bit, acc}; // RULE22
            else if (op == OP_CLO)
                o_latch <= '0;
        end
    end

    // Decode array: AND of selected true/complement bits per term
    genvar t;
    generate
        for (t = 0; t < PLA_TERMS; t++)
        begin : g_term
            assign term_hit[t] = &(~PLA_IN_MASK[t*10 +: 10] |
                {o_latch, ~o_latch}); // RULE23 RULE28
        end
    endgenerate

    always_comb
    begin
        pla_or = '0;
        for (int i = 0; i < PLA_TERMS; i++)
            if (term_hit[i])
                pla_or = pla_or | PLA_OUT_MASK[i*8 +: 8]; // RULE23
    end

    // Registered decoded outputs
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            decoded_out <= '0;
        else
            decoded_out <= pla_or;
    end

    // AXI write channel: address and data in either order
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0]; // Strobe is gone after handshake
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr <= REG_PDATA && aw_addr[1:0] == 2'h0)
                    ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Control, load address and program store writes
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl <= '0;
            paddr <= '0;
        end
        else
        begin
            ctrl.restart <= 1'b0;
            if (do_write && w_data != 32'h0 && aw_addr == REG_CTRL &&
                w_lane0)
                ctrl <= w_data[1:0];
            else if (do_write && aw_addr == REG_CTRL)
                ctrl <= '0;
            if (do_write && aw_addr == REG_PADDR)
                paddr <= w_data[9:0];
            else if (do_write && aw_addr == REG_PDATA)
                paddr <= paddr + 10'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (do_write && aw_addr == REG_PDATA)
            rom[paddr] <= w_data[7:0];
    end

    // AXI read channel
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= {30'h0, ctrl.restart, ctrl.run};
                REG_CORE: s_axi_rdata <= {10'h0, in_call, status, x, y,
                    acc, page, pc};
                REG_PINS: s_axi_rdata <= {6'h0, decoded_out, o_latch,
                    r_out};
                REG_PADDR: s_axi_rdata <= {22'h0, paddr};
                default:
                begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks on the sequencer and datapath
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_step_spacing: assert property (step |=> !step [*5]) // RULE24
        else $error("Execute pulses closer than six clocks");
    a_latch_follows: assert property (step && opc[7:5] == 3'h0 && // RULE26
        op == OP_YNEA |=> status_latch_bit == status)
        else $error("Status latch differs from status after compare");
    a_branch_taken: assert property (step && cond_ok && // RULE4
        opc[7:6] == GRP_BRANCH |=> pc == $past(opc[5:0]))
        else $error("Taken branch did not load target");
    a_branch_skip: assert property (step && !status && opc[7] |=> // RULE16
        pc == $past(next_pc))
        else $error("Branch taken with status zero");
    a_page_copy: assert property (step && cond_ok && // RULE6
        (opc[7:6] == GRP_BRANCH || !in_call) |=> page == $past(pbuf))
        else $error("Page not copied from buffer");
    a_status_one: assert property (step && !alu.use_carry && // RULE25
        !alu.use_cmp |=> status)
        else $error("Status not restored to one");
    a_carry_status: assert property (step && alu.use_carry |=> // RULE17
        status == $past(sum[4]))
        else $error("Status does not follow carry");
    a_out_latch: assert property (step && opc[7:5] == 3'h0 && // RULE22
        op == OP_TDO |=> o_latch == $past({status_latch_bit, acc}))
        else $error("Output latch not loaded");
    a_call_return: assert property (step && cond_ok && !in_call && // RULE5
        opc[7:6] == GRP_CALL |=> ret_pc == $past(next_pc))
        else $error("Return address not saved");
    c_branch: cover property (step && cond_ok && opc[7:6] == GRP_BRANCH);
    c_call: cover property (step && cond_ok && opc[7:6] == GRP_CALL);
    c_skip: cover property (step && !status && opc[7]);
    c_output: cover property (step && op == OP_TDO && opc[7:5] == 3'h0);
endmodule : fmc_core

// ==== fmc_key_model.sv ====
// Key source on the far side: sends words on the key lines once strobed.
// Assumes the strobe comes from one strobe latch of the core.
`timescale 1ns/10ps
module fmc_key_model
#(
    parameter logic [3:0] WORD_A = 4'hA,
    parameter logic [3:0] WORD_B = 4'h5,
    parameter int RATE = 1000
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Start strobe
    input wire logic strobe,
    // Key word
    output logic [3:0] keys
);
    int cnt; // Cycles since strobe rose
    // WORD_A for the first RATE cycles while strobed, then WORD_B
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt <= 0;
            keys <= 4'h0;
        end
        else if (strobe)
        begin // Switch from WORD_A to WORD_B after RATE cycles
            cnt <= cnt + 1;
            keys <= (cnt < RATE) ? WORD_A : WORD_B;
        end
        else
        begin // Idle: toggle so no stale word is seen
            cnt <= 0;
            keys <= ~keys;
        end
    end
endmodule : fmc_key_model

// ==== fmc_pkg.sv ====
// Package for the four-bit microcomputer core: sizes, opcode map,
// register offsets and the carrier structs.
// Assumes a single clock domain and an AXI4-Lite register master.
package fmc_pkg;
    // Instruction cycle length in clock pulses
    localparam int CYCLE_PULSES = 6;
    localparam logic [2:0] PHASE_LAST = 3'h5;
    // Program store, data memory, strobe line and decode array geometry
    localparam int PAGES = 16;
    localparam int PAGE_WORDS = 64;
    localparam int ROM_WORDS = PAGES * PAGE_WORDS;
    localparam int RAM_WORDS = 64;
    localparam int R_LINES = 13;
    localparam int PLA_TERMS = 20;
    localparam int O_LINES = 8;
    // Adder constants
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [3:0] NIB_ONES = 4'hF;
    localparam logic [3:0] ADD_SIX = 4'h6;
    localparam logic [3:0] ADD_EIGHT = 4'h8;
    localparam logic [3:0] ADD_TEN = 4'hA;
    // Opcode groups in the upper two bits or the upper nibble
    localparam logic [1:0] GRP_BRANCH = 2'h2;
    localparam logic [1:0] GRP_CALL = 2'h3;
    localparam logic [3:0] GRP_BITS = 4'h2;
    localparam logic [3:0] GRP_TCY = 4'h3;
    localparam logic [3:0] GRP_YNEC = 4'h4;
    localparam logic [3:0] GRP_TCMIY = 4'h5;
    localparam logic [3:0] GRP_ALEC = 4'h6;
    localparam logic [3:0] GRP_LDP = 4'h7;
    // Sub-groups of the bit group, opcode bits 3:2
    localparam logic [1:0] BITS_LDX = 2'h0;
    localparam logic [1:0] BITS_SET = 2'h1;
    localparam logic [1:0] BITS_RST = 2'h2;
    localparam logic [1:0] BITS_TEST = 2'h3;
    // Register byte offsets and response codes
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CORE = 5'h04;
    localparam logic [4:0] REG_PINS = 5'h08;
    localparam logic [4:0] REG_PADDR = 5'h0C;
    localparam logic [4:0] REG_PDATA = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Single-byte operations, opcodes 0x00 to 0x1F in this order
    typedef enum logic [4:0] {
        OP_COMX, OP_TAY, OP_TYA, OP_CLA, OP_TAM, OP_TAMIY, OP_TAMZA,
        OP_TMY, OP_TMA, OP_XMA, OP_AMAAC, OP_SAMAN, OP_IMAC, OP_DMAN,
        OP_IA, OP_IYC, OP_DAN, OP_DYN, OP_A6AAC, OP_A8AAC, OP_A10AAC,
        OP_CPAIZ, OP_ALEM, OP_MNEZ, OP_YNEA, OP_KNEZ, OP_TKA, OP_SETR,
        OP_RSTR, OP_TDO, OP_CLO, OP_RETN
    } fmc_op_e;
    // Control register fields
    typedef struct packed {
        logic restart;
        logic run;
    } fmc_ctrl_s;
    // Adder operand set
    typedef struct packed {
        logic [3:0] p;
        logic [3:0] n;
        logic cin;
        logic use_carry;
        logic use_cmp;
    } fmc_alu_s;
endpackage : fmc_pkg

// ==== tb_four_bit_mcu_core.sv ====
// Self-checking bench: loads and steps the core over AXI4-Lite.
// Assumes one clock and the key model on strobe line 5.
`timescale 1ns/10ps
module tb_four_bit_mcu_core;
    import fmc_pkg::*;
    logic ref_clk, nrst; // Clock and reset
    logic [3:0] keys; // Key word
    logic [R_LINES-1:0] r_out; // Strobe latches
    logic [O_LINES-1:0] decoded_out; // Decoded outputs
    logic status_latch_bit; // Status latch
    logic [4:0] s_axi_awaddr, s_axi_araddr; // Addresses
    logic [31:0] s_axi_wdata, s_axi_rdata, c; // Data
    logic [3:0] s_axi_wstrb; // Strobes
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp; // Responses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int fails, tests_run; // Counters
    // Core under test with three decode terms
    fmc_core #(
        .PLA_IN_MASK({170'h0, 10'h020, 10'h001, 10'h040}),
        .PLA_OUT_MASK({136'h0, 8'h04, 8'h02, 8'h81})
    ) dut_u (.ref_clk, .nrst, .key_in_bit0(keys[0]), .key_in_bit1(keys[1]),
        .key_in_bit2(keys[2]), .key_in_bit3(keys[3]), .r_out, .decoded_out,
        .status_latch_bit, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    // Peripheral started by strobe line 5
    fmc_key_model key_u (.ref_clk(ref_clk), .nrst(nrst),
        .strobe(r_out[5]), .keys(keys));
    // Verdict and end of run
    task automatic summarize;
        begin
            if (fails == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask : summarize
    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run++;
            if (seen !== exp)
            begin
                fails++;
                $display("wrong value at %0t: %h vs %h", $time, seen, exp);
            end
        end
    endtask : check
    // One AXI write, address and data offered together
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        begin
            n = 0;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge ref_clk);
                if (s_axi_awready === 1'b1)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1)
                    s_axi_wvalid <= 1'b0;
                n++;
            end
            while (s_axi_bvalid !== 1'b1 && n < 50);
            if (n >= 50)
            begin
                fails++;
                summarize();
            end
        end
    endtask : axi_wr
    // One AXI read
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        begin
            n = 0;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge ref_clk);
                if (s_axi_arready === 1'b1)
                    s_axi_arvalid <= 1'b0;
                n++;
            end
            while (s_axi_rvalid !== 1'b1 && n < 50);
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (n >= 50)
            begin
                fails++;
                summarize();
            end
        end
    endtask : axi_rd
    // Place one opcode at the current address and run one cycle
    task automatic step(input logic [7:0] op);
        begin
            axi_rd(REG_CORE, c, rsp);
            axi_wr(REG_PADDR, {22'h0, c[9:0]});
            axi_wr(REG_PDATA, {24'h0, op});
            axi_wr(REG_CTRL, 32'h1);
            repeat (7) @(posedge ref_clk);
            axi_wr(REG_CTRL, 32'h0);
            axi_rd(REG_CORE, c, rsp);
        end
    endtask : step
    // Clock at 8 ns
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Main sequence
    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 12'h0;
        {s_axi_wdata, s_axi_wstrb, fails, tests_run} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        check(32'(r_out), 32'h0);
        axi_rd(REG_CORE, c, rsp);
        check(c, 32'h001003C0);
        step(8'h35);
        check(32'(c[17:14]), 32'h5);
        step(8'h1B);
        check(32'(r_out), 32'h20);
        step(8'h1A);
        check(32'(c[13:10]), 32'hA);
        step(8'h1D);
        axi_rd(REG_PINS, c, rsp);
        check(32'(c[17:13]), 32'h0A);
        check(32'(decoded_out), 32'h83);
        step(8'h18);
        check(32'({c[20], status_latch_bit}), 32'h3);
        step(8'h45);
        check(32'(c[20]), 32'h0);
        step(8'h8A);
        check(32'({c[20], c[9:6], c[5:0] == 6'h0A}), 32'h3E);
        step(8'h03);
        step(8'h12);
        check(32'({c[20], c[13:10]}), 32'h06);
        step(8'h75);
        step(8'h8A);
        check(32'(c[9:0]), 32'h14A);
        step(8'h73);
        step(8'hD0);
        check(32'(c[21:0]), 32'h3158D0);
        step(8'h1F);
        check(32'({c[21], c[9:0]}), 32'h16A);
        axi_rd(5'h14, c, rsp);
        check(32'(rsp), 32'(RESP_SLVERR));
        axi_rd(REG_PDATA, c, rsp);
        check(32'(rsp), 32'(RESP_SLVERR));
        axi_wr(5'h14, 32'h0);
        check(32'(s_axi_bresp), 32'(RESP_SLVERR));
        summarize();
    end
endmodule : tb_four_bit_mcu_core
